// *** design/liu_interp.v ***
// Two-lane interpolator datapath with Avalon-MM register slave
//
// Contract
// - force bits OR into read result 29:28
// - raw-add bypasses shift and mask, not sum
// - swap-result pops opposite lane into accumulator
// - swap-input feeds opposite accumulator, before bypass
// - signed sign-extends shifted masked value
// - mask passes low..high inclusive; high >= low
// - logical right shift 0..31 before masking
// - add port write adds 24 bits atomically
// - add port read gives raw shift-mask value
// - packed base write loads both halves together
// - packed halves sign-extend per lane signed bit
// - both accumulators readable and writable
// - three bases readable and writable
// - take read returns result and pops accumulators
// - look read returns result, changes nothing
// - overflow flags per lane, plus their OR
// - mix mode interpolates base zero to one
`timescale 1ns/1ps
`default_nettype none
`include "liu_defs.vh"

module liu_interp (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest
);
    // Half-word extension chosen by a lane's signed bit
    function [31:0] extend_half;
        input [15:0] half;
        input is_signed;
        begin
            extend_half = {{16{is_signed & half[15]}}, half};
        end
    endfunction

    // Overlay of the forced bits on a bus-visible lane result
    function [31:0] force_bits;
        input [31:0] value;
        input [1:0] force_field;
        begin
            force_bits = value |
                {2'b00, force_field, 28'h0000000};
        end
    endfunction

    // Architectural state
    reg [31:0] accumulator_zero;
    reg [31:0] accumulator_one;
    reg [31:0] base_value_zero;
    reg [31:0] base_value_one;
    reg [31:0] base_value_two;
    reg [`LIU_CTL_ZERO_W-1:0] ctrl_first_channel;
    reg [`LIU_CTL_ONE_W-1:0] ctrl_second_channel;

    // Lane stage outputs
    wire [31:0] raw_in_zero;
    wire [31:0] raw_in_one;
    wire [31:0] shmask_zero;
    wire [31:0] shmask_one;
    wire overflow_flag_zero;
    wire overflow_flag_one;
    wire overflow_flag_any;

    // Combinational results
    reg [31:0] result_zero;
    reg [31:0] result_one;
    reg [31:0] result_sum;
    reg [32:0] mix_diff;
    reg [41:0] mix_prod;
    reg [31:0] next_readdata;
    reg [31:0] next_accumulator_zero;
    reg [31:0] next_accumulator_one;
    reg [31:0] next_base_value_zero;
    reg [31:0] next_base_value_one;
    reg [31:0] next_base_value_two;
    reg [`LIU_CTL_ZERO_W-1:0] next_ctrl_first_channel;
    reg [`LIU_CTL_ONE_W-1:0] next_ctrl_second_channel;

    // Bus handshake terms and decoded control bits
    wire accept;
    wire do_read;
    wire do_write;
    wire linear_mix_mode;
    wire raw_zero;
    wire raw_one;
    wire signed_zero;
    wire signed_one;
    wire is_take;

    assign linear_mix_mode = ctrl_first_channel[`LIU_CTL_MIX];
    assign raw_zero = ctrl_first_channel[`LIU_CTL_RAW];
    assign raw_one = ctrl_second_channel[`LIU_CTL_RAW];
    assign signed_zero = ctrl_first_channel[`LIU_CTL_SIGNED];
    assign signed_one = ctrl_second_channel[`LIU_CTL_SIGNED];

    // Lane zero stage
    liu_lane u_first_channel (
        .acc_own(accumulator_zero),
        .acc_other(accumulator_one),
        .ctrl(ctrl_first_channel[`LIU_CTL_ONE_W-1:0]),
        .raw_in(raw_in_zero),
        .shmask(shmask_zero),
        .overflow(overflow_flag_zero)
    );

    // Lane one stage
    liu_lane u_second_channel (
        .acc_own(accumulator_one),
        .acc_other(accumulator_zero),
        .ctrl(ctrl_second_channel),
        .raw_in(raw_in_one),
        .shmask(shmask_one),
        .overflow(overflow_flag_one)
    );

    assign overflow_flag_any = overflow_flag_zero | overflow_flag_one;

    // Mix difference, signed or unsigned by lane one signed bit
    always @* begin
        if (signed_one) begin
            mix_diff = {base_value_one[31], base_value_one} -
                {base_value_zero[31], base_value_zero};
        end else begin
            mix_diff = {1'b0, base_value_one} - {1'b0, base_value_zero};
        end
        // Weight is the low byte of lane one, read as n/256
        mix_prod = $signed({{9{mix_diff[32]}}, mix_diff}) *
            $signed({{34{1'h0}}, shmask_one[7:0]});
    end

    // Lane and sum results on the internal 32-bit datapath
    always @* begin
        if (linear_mix_mode) begin
            // Mix: lane zero shows the weight, sum drops lane one
            result_zero = {24'h000000, shmask_one[7:0]};
            result_one = base_value_zero + mix_prod[39:8];
            result_sum = base_value_two + shmask_zero;
        end else begin
            // Bypass takes the post-swap input, sum never bypasses
            result_zero = base_value_zero +
                (raw_zero ? raw_in_zero : shmask_zero);
            result_one = base_value_one +
                (raw_one ? raw_in_one : shmask_one);
            result_sum = base_value_two + shmask_zero + shmask_one;
        end
    end

    // One wait state; a second edge with waitrequest low releases it
    assign accept = (avs_read | avs_write) & avs_waitrequest;
    assign do_read = accept & avs_read;
    assign do_write = accept & avs_write & ~avs_read;
    assign is_take = (avs_address == `LIU_OFS_TAKE_ZERO) |
        (avs_address == `LIU_OFS_TAKE_ONE) |
        (avs_address == `LIU_OFS_TAKE_SUM);

    // Read mux; unmapped and write-only offsets read zero
    always @* begin
        case (avs_address)
            `LIU_OFS_CTRL_ZERO: begin
                next_readdata = {6'h00, overflow_flag_any, overflow_flag_one,
                    overflow_flag_zero, 1'b0, ctrl_first_channel};
            end
            `LIU_OFS_CTRL_ONE: begin
                next_readdata = {11'h000, ctrl_second_channel};
            end
            `LIU_OFS_ADD_ZERO: begin
                next_readdata = {8'h00, shmask_zero[`LIU_ADD_W-1:0]};
            end
            `LIU_OFS_ADD_ONE: begin
                // Base is not added here
                next_readdata = {8'h00, shmask_one[`LIU_ADD_W-1:0]};
            end
            `LIU_OFS_ACC_ZERO: begin
                next_readdata = accumulator_zero;
            end
            `LIU_OFS_ACC_ONE: begin
                next_readdata = accumulator_one;
            end
            `LIU_OFS_BASE_ZERO: begin
                next_readdata = base_value_zero;
            end
            `LIU_OFS_BASE_ONE: begin
                next_readdata = base_value_one;
            end
            `LIU_OFS_BASE_TWO: begin
                next_readdata = base_value_two;
            end
            `LIU_OFS_TAKE_ZERO, `LIU_OFS_LOOK_ZERO: begin
                next_readdata = force_bits(result_zero,
                    ctrl_first_channel[`LIU_CTL_FORCE_HI:`LIU_CTL_FORCE_LO]);
            end
            `LIU_OFS_TAKE_ONE, `LIU_OFS_LOOK_ONE: begin
                next_readdata = force_bits(result_one,
                    ctrl_second_channel[`LIU_CTL_FORCE_HI:`LIU_CTL_FORCE_LO]);
            end
            `LIU_OFS_TAKE_SUM, `LIU_OFS_LOOK_SUM: begin
                next_readdata = result_sum;
            end
            default: begin
                next_readdata = `LIU_RST_WORD;
            end
        endcase
    end

    // Bus answer flops: data and waitrequest come straight from here
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `LIU_RST_WORD;
        end else begin
            avs_waitrequest <= ~accept;
            if (do_read) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Accumulator next values: pops, direct writes and add ports
    always @* begin
        next_accumulator_zero = accumulator_zero;
        next_accumulator_one = accumulator_one;
        if (do_read && is_take) begin
            // Pop writes back the unforced internal results
            if (ctrl_first_channel[`LIU_CTL_SWAP_RES]) begin
                next_accumulator_zero = result_one;
            end else begin
                next_accumulator_zero = result_zero;
            end
            if (ctrl_second_channel[`LIU_CTL_SWAP_RES]) begin
                next_accumulator_one = result_zero;
            end else begin
                next_accumulator_one = result_one;
            end
        end else if (do_write) begin
            case (avs_address)
                `LIU_OFS_ACC_ZERO: begin
                    next_accumulator_zero = avs_writedata;
                end
                `LIU_OFS_ACC_ONE: begin
                    next_accumulator_one = avs_writedata;
                end
                `LIU_OFS_ADD_ZERO: begin
                    next_accumulator_zero = accumulator_zero +
                        {8'h00, avs_writedata[`LIU_ADD_W-1:0]};
                end
                `LIU_OFS_ADD_ONE: begin
                    // Upper byte of the write is ignored
                    next_accumulator_one = accumulator_one +
                        {8'h00, avs_writedata[`LIU_ADD_W-1:0]};
                end
                default: begin
                    next_accumulator_zero = accumulator_zero;
                end
            endcase
        end
    end

    // Accumulator flops; a pop updates both lanes on one edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_zero <= `LIU_RST_WORD;
            accumulator_one <= `LIU_RST_WORD;
        end else begin
            accumulator_zero <= next_accumulator_zero;
            accumulator_one <= next_accumulator_one;
        end
    end

    // Base next values: direct writes and the packed write port
    always @* begin
        next_base_value_zero = base_value_zero;
        next_base_value_one = base_value_one;
        next_base_value_two = base_value_two;
        if (do_write) begin
            case (avs_address)
                `LIU_OFS_BASE_ZERO: begin
                    next_base_value_zero = avs_writedata;
                end
                `LIU_OFS_BASE_ONE: begin
                    next_base_value_one = avs_writedata;
                end
                `LIU_OFS_BASE_TWO: begin
                    next_base_value_two = avs_writedata;
                end
                `LIU_OFS_BASE_PACKED: begin
                    // Both halves land on the same edge
                    next_base_value_zero = extend_half(avs_writedata[15:0],
                        signed_zero);
                    next_base_value_one = extend_half(avs_writedata[31:16],
                        signed_one);
                end
                default: begin
                    next_base_value_two = base_value_two;
                end
            endcase
        end
    end

    // Base flops; no half-written packed pair is ever visible
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_value_zero <= `LIU_RST_WORD;
            base_value_one <= `LIU_RST_WORD;
            base_value_two <= `LIU_RST_WORD;
        end else begin
            base_value_zero <= next_base_value_zero;
            base_value_one <= next_base_value_one;
            base_value_two <= next_base_value_two;
        end
    end

    // Lane control next values; flags above are derived, not stored
    always @* begin
        next_ctrl_first_channel = ctrl_first_channel;
        next_ctrl_second_channel = ctrl_second_channel;
        if (do_write && avs_address == `LIU_OFS_CTRL_ZERO) begin
            next_ctrl_first_channel = avs_writedata[`LIU_CTL_ZERO_W-1:0];
        end
        if (do_write && avs_address == `LIU_OFS_CTRL_ONE) begin
            next_ctrl_second_channel = avs_writedata[`LIU_CTL_ONE_W-1:0];
        end
    end

    // Lane control flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_first_channel <= `LIU_RST_CTRL_ZERO;
            ctrl_second_channel <= `LIU_RST_CTRL_ONE;
        end else begin
            ctrl_first_channel <= next_ctrl_first_channel;
            ctrl_second_channel <= next_ctrl_second_channel;
        end
    end
endmodule

`default_nettype wire

// *** design/liu_defs.vh ***
// Register offsets, field positions and reset values for the interpolator
`ifndef LIU_DEFS_VH
`define LIU_DEFS_VH

// Byte offsets on the register bus
`define LIU_OFS_CTRL_ONE 8'hB0
`define LIU_OFS_ADD_ZERO 8'hB4
`define LIU_OFS_ADD_ONE 8'hB8
`define LIU_OFS_BASE_PACKED 8'hBC
`define LIU_OFS_ACC_ZERO 8'hC0
`define LIU_OFS_ACC_ONE 8'hC4
`define LIU_OFS_BASE_ZERO 8'hC8
`define LIU_OFS_BASE_ONE 8'hCC
`define LIU_OFS_BASE_TWO 8'hD0
`define LIU_OFS_TAKE_ZERO 8'hD4
`define LIU_OFS_TAKE_ONE 8'hD8
`define LIU_OFS_TAKE_SUM 8'hDC
`define LIU_OFS_LOOK_ZERO 8'hE0
`define LIU_OFS_LOOK_ONE 8'hE4
`define LIU_OFS_LOOK_SUM 8'hE8
`define LIU_OFS_CTRL_ZERO 8'hEC

// Lane control field positions
`define LIU_CTL_OVF_ANY 25
`define LIU_CTL_OVF_ONE 24
`define LIU_CTL_OVF_ZERO 23
`define LIU_CTL_MIX 21
`define LIU_CTL_FORCE_HI 20
`define LIU_CTL_FORCE_LO 19
`define LIU_CTL_RAW 18
`define LIU_CTL_SWAP_RES 17
`define LIU_CTL_SWAP_IN 16
`define LIU_CTL_SIGNED 15
`define LIU_CTL_MSB_HI 14
`define LIU_CTL_MSB_LO 10
`define LIU_CTL_LSB_HI 9
`define LIU_CTL_LSB_LO 5
`define LIU_CTL_SHIFT_HI 4
`define LIU_CTL_SHIFT_LO 0

// Writable widths of the two lane control registers
`define LIU_CTL_ZERO_W 22
`define LIU_CTL_ONE_W 21

// Forced result bits and add port width
`define LIU_FORCE_BIT_HI 29
`define LIU_FORCE_BIT_LO 28
`define LIU_ADD_W 24

// Reset values
`define LIU_RST_WORD 32'h00000000
`define LIU_RST_CTRL_ZERO 22'h000000
`define LIU_RST_CTRL_ONE 21'h000000

`endif

// *** design/liu_lane.v ***
// One lane shift, mask and sign-extension stage with overflow detect
`timescale 1ns/1ps
`default_nettype none
`include "liu_defs.vh"

module liu_lane (
    input wire [31:0] acc_own,
    input wire [31:0] acc_other,
    input wire [20:0] ctrl,
    output wire [31:0] raw_in,
    output wire [31:0] shmask,
    output wire overflow
);
    wire [4:0] shift;
    wire [4:0] lsb;
    wire [4:0] msb;
    wire [31:0] shifted;
    wire [31:0] lo_mask;
    wire [31:0] hi_mask;
    wire [31:0] masked;

    assign shift = ctrl[`LIU_CTL_SHIFT_HI:`LIU_CTL_SHIFT_LO];
    assign lsb = ctrl[`LIU_CTL_LSB_HI:`LIU_CTL_LSB_LO];
    assign msb = ctrl[`LIU_CTL_MSB_HI:`LIU_CTL_MSB_LO];

    // Input mux sits ahead of the raw bypass taken in the parent
    assign raw_in = ctrl[`LIU_CTL_SWAP_IN] ? acc_other : acc_own;

    // Logical shift first, then the inclusive window
    assign shifted = raw_in >> shift;
    assign lo_mask = 32'hFFFFFFFF << lsb;
    assign hi_mask = 32'hFFFFFFFF >> (5'h1F - msb);
    // Window undefined when msb < lsb; result is simply all zero then
    assign masked = shifted & lo_mask & hi_mask;

    // Sign copies the top passed bit over everything above it
    assign shmask = (ctrl[`LIU_CTL_SIGNED] && masked[msb]) ?
        (masked | ~hi_mask) : masked;

    // Any shifted bit discarded above the high bound
    assign overflow = |(shifted & ~hi_mask);
endmodule

`default_nettype wire

// *** bench/liu_chk_checker.sv ***
// Bus timing and readback checker for the interpolator register port
`timescale 1ns/1ps
`default_nettype none
module liu_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire rd_t = avs_read && avs_waitrequest;
    wire wr_t = avs_write && avs_waitrequest;
    logic look_p, look_ok, acc_ok;
    logic [7:0] look_adr;
    logic [31:0] look_val, acc_val;
    // Any write or take read voids the look shadow and the accumulator shadow, except a write to C0 reloads it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            look_p <= 1'b0;
            look_ok <= 1'b0;
            acc_ok <= 1'b0;
        end else begin
            look_p <= rd_t && avs_address >= 8'hE0 && avs_address <= 8'hE8;
            if (look_p) begin
                look_ok <= 1'b1;
                look_val <= avs_readdata;
            end
            if (rd_t && avs_address >= 8'hE0 && avs_address <= 8'hE8) look_adr <= avs_address;
            if (wr_t || (rd_t && avs_address >= 8'hD4 && avs_address <= 8'hDC)) begin
                look_ok <= 1'b0;
                acc_ok <= wr_t && avs_address == 8'hC0;
                acc_val <= avs_writedata;
            end
        end
    end
    take_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without request");
    data_hold_a: assert property (!rd_t |=> $stable(avs_readdata))
        else $error("readdata moved without read");
    void_zero_a: assert property (rd_t && (avs_address == 8'hBC || avs_address < 8'hB0
        || avs_address > 8'hEC) |=> avs_readdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    add_upper_a: assert property (rd_t && (avs_address == 8'hB4 || avs_address == 8'hB8)
        |=> avs_readdata[31:24] == 8'h00)
        else $error("add port upper bits set");
    look_same_a: assert property (rd_t && look_ok && !look_p && avs_address == look_adr
        |=> avs_readdata == look_val)
        else $error("look read changed state");
    acc_back_a: assert property (rd_t && acc_ok && avs_address == 8'hC0
        |=> avs_readdata == acc_val)
        else $error("accumulator readback wrong");
endmodule
bind liu_interp liu_chk chk_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** bench/liu_host.sv ***
// Processor side bus master model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module liu_host (
    input wire logic clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // Request held until waitrequest is sampled low; bounded so a hang ends the run
    task xfer(input logic wr_en, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        integer n;
        begin
            @(posedge clk);
            avs_address <= adr;
            avs_read <= !wr_en;
            avs_write <= wr_en;
            avs_writedata <= wd;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (avs_waitrequest !== 1'b0 && n < 50);
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (avs_waitrequest !== 1'b0) begin
                tb.mismatches++;
                tb.stop_test();
            end
        end
    endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Register level testbench for the interpolator datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire [7:0] adr;
    wire rd, wr, wtr;
    wire [31:0] wd, rdd;
    logic [31:0] a0, a1, b0, b1, b2, got, r0, r1;
    logic [20:0] c0, c1;
    integer mismatches = 0, checks_done = 0, i;
    logic [7:0] ra [5] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0};
    logic [31:0] rv [5] = '{32'h12345678, 32'h00008F00, 32'h00000100, 32'h00002000, 32'h00030000};
    // None, force, raw, swap input, raw with swap, signed
    logic [20:0] md [6] = '{21'h0, 21'h180000, 21'h040000, 21'h010000, 21'h050000, 21'h008000};
    localparam logic [20:0] CB = 21'h002C84; // Shift 4, bits 4..11; high bound above low
    always #50 clk = ~clk;
    liu_interp dut_u (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdd), .avs_waitrequest(wtr));
    liu_host host_u (.clk(clk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdd), .avs_waitrequest(wtr));
    task w(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, got);
    endtask
    task ex(input logic [7:0] a, input logic [31:0] e);
        begin
            host_u.xfer(1'b0, a, 32'h0, got);
            checks_done++;
            if (got !== e) begin
                mismatches++;
                $display("BAD reg %h expected %h seen %h", a, e, got);
            end
        end
    endtask
    // Shift, keep bits low..high, optionally extend from the high bit
    function logic [31:0] sm(input logic [31:0] a, input logic [20:0] c);
        integer k;
        begin
            sm = a >> c[4:0];
            for (k = 0; k < 32; k++)
                if (k < c[9:5] || k > c[14:10]) sm[k] = c[15] && k > c[14:10] && sm[c[14:10]];
        end
    endfunction
    function logic ov(input logic [31:0] a, input logic [20:0] c);
        ov = |((a >> c[4:0]) >> c[14:10] >> 1);
    endfunction
    function logic [31:0] l1(input logic [20:0] c);
        logic [31:0] src;
        begin
            src = c[16] ? a0 : a1;
            l1 = (c[18] ? src : sm(src, c)) + b1;
            l1[29:28] = l1[29:28] | c[20:19];
        end
    endfunction
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, then readback of accumulators and bases
        ex(8'hB0, 32'h0);
        ex(8'hE8, 32'h0);
        for (i = 0; i < 5; i++) ex(ra[i], 32'h0);
        for (i = 0; i < 5; i++) begin
            w(ra[i], rv[i]);
            ex(ra[i], rv[i]);
        end
        {a0, a1, b0, b1, b2} = {rv[0], rv[1], rv[2], rv[3], rv[4]};
        c0 = 21'h001C08;
        c1 = CB;
        w(8'hEC, {11'h0, c0});
        w(8'hB0, {11'h0, c1});
        ex(8'hB8, sm(a1, c1) & 32'h00FFFFFF);
        ex(8'hB4, sm(a0, c0) & 32'h00FFFFFF);
        ex(8'hE4, l1(c1));
        ex(8'hE4, l1(c1));
        ex(8'hE8, b2 + sm(a0, c0) + sm(a1, c1));
        ex(8'hEC, {6'h0, ov(a0, c0) | ov(a1, c1), ov(a1, c1), ov(a0, c0), 2'b00, c0});
        ex(8'hC4, a1);
        // Each lane mode in turn; datapath values must stay unforced
        for (i = 0; i < 6; i++) begin
            c1 = CB | md[i];
            w(8'hB0, {11'h0, c1});
            ex(8'hE4, l1(c1));
            ex(8'hE8, b2 + sm(a0, c0) + sm(c1[16] ? a0 : a1, c1));
            ex(8'hC4, a1);
        end
        w(8'hB8, 32'hFF000010);
        a1 = a1 + 32'h10;
        ex(8'hC4, a1);
        r0 = b0 + sm(a0, c0);
        r1 = l1(c1);
        ex(8'hD8, r1);
        a0 = r0;
        a1 = r1;
        ex(8'hC0, a0);
        ex(8'hC4, a1);
        c1 = CB | 21'h020000;
        w(8'hB0, {11'h0, c1});
        r0 = b0 + sm(a0, c0);
        ex(8'hD4, r0);
        ex(8'hC4, r0);
        ex(8'hC0, r0);
        w(8'hB0, {11'h0, CB | 21'h008000});
        w(8'hBC, 32'h80018002);
        ex(8'hC8, 32'h00008002);
        ex(8'hCC, 32'hFFFF8001);
        ex(8'hBC, 32'h0);
        ex(8'h00, 32'h0);
        // Mix mode: unsigned half-way weight, then signed with base one below
        w(8'hC4, 32'h00000800);
        w(8'hC8, 32'h00000100);
        w(8'hCC, 32'h00000200);
        w(8'hB0, {11'h0, CB});
        w(8'hEC, 32'h00200000 | {11'h0, c0});
        ex(8'hE4, 32'h00000180);
        ex(8'hE0, 32'h00000080);
        ex(8'hE8, b2 + sm(r0, c0));
        w(8'hB0, {11'h0, CB | 21'h008000});
        w(8'hC8, 32'h00000200);
        w(8'hCC, 32'hFFFFFF00);
        ex(8'hE4, 32'h00000080);
        // Mid-run reset returns every register to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ex(8'hEC, 32'h0);
        ex(8'hC4, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
